//--- rtl/rdv_pkg.sv
// Constants and types of the deviation and state configuration bank
`default_nettype none
package rdv_pkg;

  // ***********************************
  // Register port
  // ***********************************
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  localparam logic [5:0] ADDR_DEVIATION = 6'h15;
  localparam logic [5:0] ADDR_RX_TIMEOUT = 6'h16;
  localparam logic [5:0] ADDR_NEXT_STATE = 6'h17;

  // Writable bits only; the rest stays zero
  localparam logic [7:0] MASK_DEVIATION = 8'h77;
  localparam logic [7:0] MASK_RX_TIMEOUT = 8'h1f;
  localparam logic [7:0] MASK_NEXT_STATE = 8'h3f;

  localparam logic [7:0] RESET_DEVIATION = 8'h47;
  localparam logic [7:0] RESET_RX_TIMEOUT = 8'h07;
  localparam logic [7:0] RESET_NEXT_STATE = 8'h30;

  // ***********************************
  // Field positions
  // ***********************************
  localparam int unsigned DEV_E_LSB = 4;
  localparam int unsigned DEV_M_LSB = 0;
  localparam int unsigned CS_RX_END_BIT = 4;
  localparam int unsigned CLEAR_CHANNEL_MODE_LSB = 4;
  localparam int unsigned AFTER_RX_LSB = 2;
  localparam int unsigned AFTER_TX_LSB = 0;

  // ***********************************
  // Deviation arithmetic
  // ***********************************
  // Units of crystal frequency over 2^17; max (8+7)<<7 = 1920
  localparam int unsigned DEV_W = 11;
  localparam int unsigned OFS_W = 12;
  localparam logic [3:0] DEV_IMPLICIT_ONE = 4'h8;

  // ***********************************
  // Receive termination
  // ***********************************
  localparam logic [3:0] OOK_CS_SYMBOLS = 4'h8;

  // ***********************************
  // Enumerations
  // ***********************************
  typedef enum logic [1:0] {
    MOD_2FSK = 2'h0,
    MOD_GFSK = 2'h1,
    MOD_4FSK = 2'h2,
    MOD_OOK  = 2'h3
  } rdv_mod_t;

  typedef enum logic [1:0] {
    CCA_ALWAYS     = 2'h0,
    CCA_RSSI       = 2'h1,
    CCA_NOT_RX     = 2'h2,
    CCA_RSSI_NO_RX = 2'h3
  } rdv_cca_t;

  // Code of both next-state fields equals this encoding
  typedef enum logic [1:0] {
    RS_IDLE     = 2'h0,
    RS_SYNTH_ON = 2'h1,
    RS_TX       = 2'h2,
    RS_RX       = 2'h3
  } rdv_radio_state_t;

  // Gray sequence off -> wait -> sense -> end
  typedef enum logic [1:0] {
    TS_OFF   = 2'b00,
    TS_WAIT  = 2'b01,
    TS_SENSE = 2'b11,
    TS_END   = 2'b10
  } rdv_term_state_t;

endpackage
`default_nettype wire

//--- rtl/rdv_cfg_reg.sv
// One masked configuration register on the register port
`timescale 1ns/1ps
`default_nettype none
module rdv_cfg_reg #(
  parameter logic [5:0] ADDR  = 6'h00,
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] MASK  = 8'hff
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [5:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  output logic      [7:0] q_o
);

  // Unused bits are never stored, so they read as zero
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q_o <= RESET & MASK;
    end
    else if (reg_wr_i && (reg_addr_i == ADDR))
    begin
      q_o <= reg_wdata_i & MASK;
    end
  end

endmodule
`default_nettype wire

//--- rtl/rdv_top.sv
// Deviation and radio state configuration bank with its local effects
`timescale 1ns/1ps
`default_nettype none
module rdv_top (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [1:0]  mod_format_i,
  input  wire logic        tx_active_i,
  input  wire logic        tx_symbol_i,
  input  wire logic        rx_active_i,
  input  wire logic        carrier_sense_i,
  input  wire logic        symbol_tick_i,
  input  wire logic        rssi_below_i,
  input  wire logic        receiving_pkt_i,
  input  wire logic        rx_done_i,
  input  wire logic        tx_done_i,
  output logic signed [11:0] carrier_offset_o,
  output logic      [10:0] rx_expected_dev_o,
  output logic             rx_terminate_o,
  output logic             clear_channel_indication_o,
  output logic      [1:0]  next_state_o,
  output logic             next_state_valid_o,
  output logic             restart_preamble_o
);

  // ***********************************
  // Registers
  // ***********************************
  logic [7:0] freq_deviation_reg;
  logic [7:0] sm_config_rx_timeout_reg;
  logic [7:0] sm_config_next_state_reg;

  rdv_cfg_reg #(
    .ADDR  (rdv_pkg::ADDR_DEVIATION),
    .RESET (rdv_pkg::RESET_DEVIATION),
    .MASK  (rdv_pkg::MASK_DEVIATION)
  ) u_dev_reg (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .q_o         (freq_deviation_reg)
  );

  rdv_cfg_reg #(
    .ADDR  (rdv_pkg::ADDR_RX_TIMEOUT),
    .RESET (rdv_pkg::RESET_RX_TIMEOUT),
    .MASK  (rdv_pkg::MASK_RX_TIMEOUT)
  ) u_rxt_reg (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .q_o         (sm_config_rx_timeout_reg)
  );

  rdv_cfg_reg #(
    .ADDR  (rdv_pkg::ADDR_NEXT_STATE),
    .RESET (rdv_pkg::RESET_NEXT_STATE),
    .MASK  (rdv_pkg::MASK_NEXT_STATE)
  ) u_nxt_reg (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .q_o         (sm_config_next_state_reg)
  );

  // Read data held until the next read; unmapped reads give zero
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        rdv_pkg::ADDR_DEVIATION:  reg_rdata_o <= freq_deviation_reg;
        rdv_pkg::ADDR_RX_TIMEOUT: reg_rdata_o <= sm_config_rx_timeout_reg;
        rdv_pkg::ADDR_NEXT_STATE: reg_rdata_o <= sm_config_next_state_reg;
        default:                  reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ***********************************
  // Fields
  // ***********************************
  logic [2:0] dev_exp;
  logic [2:0] dev_man;
  logic       carrier_sense_rx_end;
  logic [1:0] clear_channel_mode;
  logic [1:0] after_rx_state;
  logic [1:0] after_tx_state;
  logic       is_ook;

  assign dev_exp = freq_deviation_reg[rdv_pkg::DEV_E_LSB +: 3];
  assign dev_man = freq_deviation_reg[rdv_pkg::DEV_M_LSB +: 3];
  assign carrier_sense_rx_end =
    sm_config_rx_timeout_reg[rdv_pkg::CS_RX_END_BIT];
  assign clear_channel_mode =
    sm_config_next_state_reg[rdv_pkg::CLEAR_CHANNEL_MODE_LSB +: 2];
  assign after_rx_state = sm_config_next_state_reg[rdv_pkg::AFTER_RX_LSB +: 2];
  assign after_tx_state = sm_config_next_state_reg[rdv_pkg::AFTER_TX_LSB +: 2];
  assign is_ook = (mod_format_i == rdv_pkg::MOD_OOK);

  // ***********************************
  // Deviation
  // ***********************************
  logic [10:0] dev_units;
  logic [11:0] dev_pos;

  // Implicit leading one makes the mantissa four bits
  assign dev_units = 11'({1'b1, dev_man}) << dev_exp;
  assign dev_pos   = {1'b0, dev_units};

  // Zero below carrier, one above; nothing in OOK
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      carrier_offset_o <= '0;
    else if (tx_active_i && !is_ook)
      carrier_offset_o <= tx_symbol_i ? $signed(dev_pos)
                                      : $signed(12'(-dev_pos));
    else
      carrier_offset_o <= '0;
  end

  // Demodulator expectation, zero in OOK
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rx_expected_dev_o <= '0;
    else
      rx_expected_dev_o <= is_ook ? '0 : dev_units;
  end

  // ***********************************
  // Receive termination
  // ***********************************
  rdv_pkg::rdv_term_state_t term_state;
  rdv_pkg::rdv_term_state_t next_term_state;
  logic [3:0]               sym_cnt;
  logic                     ook_expired;

  // OOK waits a fixed symbol count for carrier sense
  assign ook_expired = symbol_tick_i &&
    (sym_cnt == (rdv_pkg::OOK_CS_SYMBOLS - 4'h1));

  always_comb
  begin
    next_term_state = term_state;
    unique case (term_state)
      rdv_pkg::TS_OFF:
        if (rx_active_i && carrier_sense_rx_end)
          next_term_state = rdv_pkg::TS_WAIT;
      rdv_pkg::TS_WAIT:
        if (!rx_active_i || !carrier_sense_rx_end)
          next_term_state = rdv_pkg::TS_OFF;
        else if (carrier_sense_i)
          next_term_state = rdv_pkg::TS_SENSE;
        else if (is_ook ? ook_expired : symbol_tick_i)
          next_term_state = rdv_pkg::TS_END;
      rdv_pkg::TS_SENSE:
        if (!rx_active_i || !carrier_sense_rx_end)
          next_term_state = rdv_pkg::TS_OFF;
        else if (!carrier_sense_i)
          next_term_state = rdv_pkg::TS_END;
      rdv_pkg::TS_END:
        if (!rx_active_i)
          next_term_state = rdv_pkg::TS_OFF;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      term_state <= rdv_pkg::TS_OFF;
    else
      term_state <= next_term_state;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sym_cnt <= 4'h0;
    else if (term_state != rdv_pkg::TS_WAIT)
      sym_cnt <= 4'h0;
    else if (symbol_tick_i)
      sym_cnt <= sym_cnt + 4'h1;
  end

  // One pulse per receive; the radio must drop rx_active to rearm
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rx_terminate_o <= 1'b0;
    else
      rx_terminate_o <= (next_term_state == rdv_pkg::TS_END) &&
                        (term_state != rdv_pkg::TS_END);
  end

  // ***********************************
  // Clear channel
  // ***********************************
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clear_channel_indication_o <= 1'b0;
    end
    else
    begin
      unique case (clear_channel_mode)
        rdv_pkg::CCA_ALWAYS:
          clear_channel_indication_o <= 1'b1;
        rdv_pkg::CCA_RSSI:
          clear_channel_indication_o <= rssi_below_i;
        rdv_pkg::CCA_NOT_RX:
          clear_channel_indication_o <= !receiving_pkt_i;
        rdv_pkg::CCA_RSSI_NO_RX:
          clear_channel_indication_o <= rssi_below_i && !receiving_pkt_i;
      endcase
    end
  end

  // ***********************************
  // Next state after a packet
  // ***********************************
  // Receive completion wins; the two never coincide in a sane radio
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      next_state_o       <= rdv_pkg::RS_IDLE;
      next_state_valid_o <= 1'b0;
    end
    else
    begin
      next_state_valid_o <= rx_done_i || tx_done_i;
      if (rx_done_i)
        next_state_o <= after_rx_state;
      else if (tx_done_i)
        next_state_o <= after_tx_state;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      restart_preamble_o <= 1'b0;
    else
      restart_preamble_o <= tx_done_i && !rx_done_i &&
                            (after_tx_state == rdv_pkg::RS_TX);
  end

  // ***********************************
  // Assertions
  // ***********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic [11:0] exp_dev;
  assign exp_dev = (12'(rdv_pkg::DEV_IMPLICIT_ONE) + 12'(dev_man)) << dev_exp;

  a_tx_dev_up: assert property (
    tx_active_i && !is_ook && tx_symbol_i |=>
      carrier_offset_o == $signed($past(exp_dev)))
    else $error("Upward deviation wrong");
  a_tx_dev_down: assert property (
    tx_active_i && !is_ook && !tx_symbol_i |=>
      carrier_offset_o == -$signed($past(exp_dev)))
    else $error("Downward deviation wrong");
  a_rx_expect_dev: assert property (
    !is_ook |=> rx_expected_dev_o == $past(exp_dev[10:0]))
    else $error("Expected deviation wrong");
  a_ook_ignores_dev: assert property (
    is_ook |=> carrier_offset_o == 12'sh000 && rx_expected_dev_o == 11'h000)
    else $error("OOK used deviation");
  a_cs_drop_ends: assert property (
    term_state == rdv_pkg::TS_SENSE && rx_active_i && !carrier_sense_i &&
      carrier_sense_rx_end |=> rx_terminate_o ##1 !rx_terminate_o)
    else $error("Carrier loss did not end receive");
  a_ook_cs_timeout: assert property (
    term_state == rdv_pkg::TS_WAIT && rx_active_i && is_ook &&
      carrier_sense_rx_end && !carrier_sense_i && symbol_tick_i &&
      sym_cnt == rdv_pkg::OOK_CS_SYMBOLS - 4'h1 |=> rx_terminate_o)
    else $error("OOK timeout missed");
  a_clear_channel_mode_out: assert property (
    clear_channel_mode == rdv_pkg::CCA_RSSI_NO_RX |=>
      clear_channel_indication_o == $past(rssi_below_i && !receiving_pkt_i))
    else $error("Clear channel wrong");
  a_after_rx_state: assert property (
    rx_done_i |=> next_state_valid_o && next_state_o == $past(after_rx_state))
    else $error("Post receive state wrong");
  a_after_tx_state: assert property (
    tx_done_i && !rx_done_i |=>
      next_state_valid_o && next_state_o == $past(after_tx_state))
    else $error("Post transmit state wrong");
  a_preamble_restart: assert property (
    restart_preamble_o |-> next_state_valid_o &&
      next_state_o == rdv_pkg::RS_TX)
    else $error("Preamble restart without stay in transmit");
  a_unused_bits_zero: assert property (
    reg_rd_i && reg_addr_i == rdv_pkg::ADDR_DEVIATION |=>
      (reg_rdata_o & ~rdv_pkg::MASK_DEVIATION) == 8'h00)
    else $error("Unused bits not zero");

  c_rx_terminated: cover property (rx_terminate_o);
  c_carrier_lost: cover property (term_state == rdv_pkg::TS_SENSE &&
    rx_active_i && !carrier_sense_i);
  c_preamble_again: cover property (restart_preamble_o);
  c_ook_timeout: cover property (is_ook && rx_terminate_o);

endmodule
`default_nettype wire

//--- testbench/rdv_host_model.sv
// Host side of the register port: single-word writes and reads
`timescale 1ns/1ps
`default_nettype none
module rdv_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [5:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o
);
  // ***********************************
  // Bus cycles
  // ***********************************
  // Entered just after a rising edge; a strobe cycle, then an idle cycle
  initial
  begin
    reg_addr_o  = 6'h3f;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // Released lines show the inverse, so a stale value cannot pass
  task automatic release_bus();
    reg_addr_o  = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask

  // Deviation is whatever the caller programs; no range check here
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    release_bus();
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [5:0] addr, output logic [7:0] data);
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    data     = reg_rdata_i;
    release_bus();
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the deviation and state configuration bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               clk_i;
  logic               resetn_i;
  logic        [5:0]  reg_addr;
  logic        [7:0]  reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic        [7:0]  reg_rdata;
  logic        [1:0]  mod_format_i;
  logic               tx_active_i;
  logic               tx_symbol_i;
  logic               rx_active_i;
  logic               carrier_sense_i;
  logic               symbol_tick_i;
  logic               rssi_below_i;
  logic               receiving_pkt_i;
  logic               rx_done_i;
  logic               tx_done_i;
  logic signed [11:0] carrier_offset_o;
  logic        [10:0] rx_expected_dev_o;
  logic               rx_terminate_o;
  logic               cca_o;
  logic        [1:0]  next_state_o;
  logic               next_state_valid_o;
  logic               restart_preamble_o;
  int                 errors;
  int                 n_compared;
  logic        [7:0]  d;
  logic        [11:0] dev;
  logic        [11:0] ex;
  logic        [7:0]  dev_tab [4] = '{8'h00, 8'hff, 8'h47, 8'h3a};
  logic        [7:0]  rst_tab [4] = '{8'h47, 8'h07, 8'h30, 8'h00};
  logic        [7:0]  msk_tab [4] = '{8'h77, 8'h1f, 8'h3f, 8'h00};

  rdv_top i_rdv_top (
    .clk_i                      (clk_i),
    .resetn_i                   (resetn_i),
    .reg_addr_i                 (reg_addr),
    .reg_wdata_i                (reg_wdata),
    .reg_wr_i                   (reg_wr),
    .reg_rd_i                   (reg_rd),
    .reg_rdata_o                (reg_rdata),
    .mod_format_i               (mod_format_i),
    .tx_active_i                (tx_active_i),
    .tx_symbol_i                (tx_symbol_i),
    .rx_active_i                (rx_active_i),
    .carrier_sense_i            (carrier_sense_i),
    .symbol_tick_i              (symbol_tick_i),
    .rssi_below_i               (rssi_below_i),
    .receiving_pkt_i            (receiving_pkt_i),
    .rx_done_i                  (rx_done_i),
    .tx_done_i                  (tx_done_i),
    .carrier_offset_o           (carrier_offset_o),
    .rx_expected_dev_o          (rx_expected_dev_o),
    .rx_terminate_o             (rx_terminate_o),
    .clear_channel_indication_o (cca_o),
    .next_state_o               (next_state_o),
    .next_state_valid_o         (next_state_valid_o),
    .restart_preamble_o         (restart_preamble_o)
  );

  rdv_host_model i_rdv_host_model (
    .clk_i       (clk_i),
    .reg_rdata_i (reg_rdata),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata),
    .reg_wr_o    (reg_wr),
    .reg_rd_o    (reg_rd)
  );

  // ***********************************
  // Helpers
  // ***********************************
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // All inputs move 1 ns after the edge, outputs settled by then
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Receive run: fire is the tick number that must end receive, 0 never
  task automatic rx_run(input logic [1:0] f, input int n, input int fire);
    mod_format_i = f;
    rx_active_i  = 1'b1;
    step(2);
    for (int i = 1; i <= n; i++)
    begin
      symbol_tick_i = 1'b1;
      step(1);
      symbol_tick_i = 1'b0;
      chk(12'(rx_terminate_o), 12'(i == fire));
      step(1);
      chk(12'(rx_terminate_o), 12'h000);
    end
    rx_active_i = 1'b0;
    step(2);
  endtask

  // ***********************************
  // Watchdog
  // ***********************************
  // Tests take under two hundred cycles; 10000 cycles means a hang
  initial
  begin
    #50000;
    errors++;
    wrap_up();
  end

  // ***********************************
  // Tests
  // ***********************************
  initial
  begin
    errors          = 0;
    n_compared      = 0;
    resetn_i        = 1'b0;
    mod_format_i    = 2'h0;
    tx_active_i     = 1'b0;
    tx_symbol_i     = 1'b0;
    rx_active_i     = 1'b0;
    carrier_sense_i = 1'b0;
    symbol_tick_i   = 1'b0;
    rssi_below_i    = 1'b1;
    receiving_pkt_i = 1'b0;
    rx_done_i       = 1'b0;
    tx_done_i       = 1'b0;
    step(10);
    resetn_i = 1'b1;
    step(2);
    chk(12'(rx_expected_dev_o), 12'd240);
    chk(12'(cca_o), 12'h001);
    for (int a = 0; a < 4; a++)
    begin
      i_rdv_host_model.rd(6'h15 + 6'(a), d);
      chk(12'(d), 12'(rst_tab[a]));
      i_rdv_host_model.wr(6'h15 + 6'(a), 8'hff);
      i_rdv_host_model.rd(6'h15 + 6'(a), d);
      chk(12'(d), 12'(msk_tab[a]));
    end
    tx_active_i = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      i_rdv_host_model.wr(6'h15, dev_tab[k]);
      dev = (12'h008 + 12'(dev_tab[k][2:0])) << dev_tab[k][6:4];
      for (int f = 0; f < 8; f++)
      begin
        mod_format_i = 2'(f >> 1);
        tx_symbol_i  = f[0];
        step(1);
        ex = (f >= 6) ? 12'h000 : (f[0] ? dev : -dev);
        chk(carrier_offset_o, ex);
        ex = (f >= 6) ? 12'h000 : dev;
        chk(12'(rx_expected_dev_o), ex);
      end
    end
    tx_active_i = 1'b0;
    for (int md = 0; md < 4; md++)
    begin
      i_rdv_host_model.wr(6'h17, {2'b00, 2'(md), 4'h0});
      for (int c = 0; c < 4; c++)
      begin
        rssi_below_i    = c[0];
        receiving_pkt_i = c[1];
        step(1);
        case (md)
          0: ex = 12'h001;
          1: ex = 12'(c[0]);
          2: ex = 12'(!c[1]);
          default: ex = 12'(c[0] && !c[1]);
        endcase
        chk(12'(cca_o), ex);
      end
    end
    for (int c = 0; c < 4; c++)
    begin
      i_rdv_host_model.wr(6'h17, {4'h3, 2'(c), 2'(3 - c)});
      rx_done_i = 1'b1;
      step(1);
      rx_done_i = 1'b0;
      chk(12'(next_state_valid_o), 12'h001);
      chk(12'(next_state_o), 12'(c));
      chk(12'(restart_preamble_o), 12'h000);
      step(1);
      chk(12'(next_state_valid_o), 12'h000);
      tx_done_i = 1'b1;
      step(1);
      tx_done_i = 1'b0;
      chk(12'(next_state_valid_o), 12'h001);
      chk(12'(next_state_o), 12'(3 - c));
      chk(12'(restart_preamble_o), 12'(c == 1));
      step(1);
      chk(12'(restart_preamble_o), 12'h000);
    end
    i_rdv_host_model.wr(6'h16, 8'h07);
    rx_run(2'h0, 3, 0);
    i_rdv_host_model.wr(6'h16, 8'h17);
    rx_run(2'h0, 1, 1);
    rx_run(2'h3, 8, 8);
    carrier_sense_i = 1'b1;
    rx_run(2'h3, 8, 0);
    // Carrier seen, then lost: receive must end on the drop
    mod_format_i = 2'h0;
    rx_active_i  = 1'b1;
    step(3);
    carrier_sense_i = 1'b0;
    step(1);
    chk(12'(rx_terminate_o), 12'h001);
    step(1);
    chk(12'(rx_terminate_o), 12'h000);
    rx_active_i = 1'b0;
    step(2);
    wrap_up();
  end
endmodule
`default_nettype wire
